// ===== rtl/mtc_pkg.sv
// Functional notes
// - resolution pins LLL full, HLL half, LHL quarter, HHL eighth, HHH sixteenth.
// - reset loads Home DAC codes and polarities, mixed decay on both phases.
// - each step rising edge advances index by resolution increment, updating DACs.
// - automatic mode picks mixed when new level is lower, else slow.
// - resolution pins take effect only at the next step rising edge.
// - direction pin takes effect only at next step edge, choosing index sense.
// - thermal shutdown or overcurrent returns translator to Home.
// - mixed decay runs fast for 31.25% of off-time, then slow.
// - pin tied high gives 30 us off-time, automatic mixed, slow in full step.
// - pin grounded gives 30 us off-time, mixed decay always in every resolution.
// - resistor mode off-time in us is resistance over 825, automatic decay.
// - while reset is low hold Home, bridges off, step pulses ignored.
// - drive enables diagonal pair; comparator trip ends drive and starts off-time.
// - comparator ignored for about 1 us after each drive switch-on.
// - one-shot holds bridge off for whole off-time, then drive restarts.
// - DAC code is step percentage of full-scale trip current.
// - output-enable high disables bridges; translator keeps working regardless.
//
// package of constants and carrier types for the translator/chopper block
// assumes a 100 MHz system clock
package mtc_pkg;

    localparam int CLK_NS = 10;

    // apb map (byte addresses)
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_PHASE  = 8'h08;

    // control register fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_OFFTIME_CONFIG_PIN_LSB = 8;
    localparam logic [1:0] CTRL_MODE_RST = 2'h0;
    localparam logic [7:0] CTRL_OFFTIME_CONFIG_PIN_RST = 8'h19;

    // timing
    localparam int BLANK_NS     = 1000;
    localparam int BLANK_CYC    = (BLANK_NS + CLK_NS - 1) / CLK_NS;
    localparam int OFF_US       = 30;
    localparam int OFF_CYC      = OFF_US * 1000 / CLK_NS;
    localparam int OFFTIME_CONFIG_PIN_DIV_OHM = 825;
    localparam int OFFTIME_CONFIG_PIN_SHIFT   = 5;
    localparam int OFFTIME_CONFIG_PIN_MUL     = (1000 * (1000 / CLK_NS) * (1 << OFFTIME_CONFIG_PIN_SHIFT)) / OFFTIME_CONFIG_PIN_DIV_OHM;
    localparam int OFF_MIN_CYC  = 16;
    localparam int FAST_NUM     = 5;
    localparam int FAST_SHIFT   = 4;

    // translator
    localparam logic [5:0] HOME_IDX = 6'h08;
    localparam logic [5:0] QUARTER  = 6'h10;

    typedef enum logic [2:0] {
        RES_FULL    = 3'b000,
        RES_HALF    = 3'b001,
        RES_QUARTER = 3'b010,
        RES_EIGHTH  = 3'b011,
        RES_SIXTEEN = 3'b100
    } mtc_res_type;

    typedef enum logic [1:0] {
        OFF_TIED_HIGH = 2'b00,
        OFF_GROUNDED  = 2'b01,
        OFF_RESISTOR  = 2'b10
    } mtc_offmode_type;

    typedef enum logic [1:0] {
        BR_OFF   = 2'b00,
        BR_DRIVE = 2'b01,
        BR_FAST  = 2'b10,
        BR_SLOW  = 2'b11
    } mtc_bridge_type;

    typedef enum logic [2:0] {
        CH_IDLE  = 3'b000,
        CH_BLANK = 3'b001,
        CH_ON    = 3'b010,
        CH_FAST  = 3'b011,
        CH_SLOW  = 3'b100
    } mtc_chop_type;

    typedef struct packed {
        logic           polarity;
        logic [7:0]     dac;
        logic           mixed;
        mtc_bridge_type bridge;
    } mtc_phase_type;

endpackage

// ===== rtl/mtc_translator_chopper.sv
// microstep translator with two fixed off-time pwm choppers and an apb slave
// assumes all inputs synchronous to clk_in; comparator trips come from analog sense
`timescale 1ns/100ps
module mtc_translator_chopper
    import mtc_pkg::*;
#(
    parameter int CNT_W = 16
) (
    // clock and reset
    input  wire logic                clk_in,
    input  wire logic                rstn_in,
    // apb slave
    input  wire logic                psel_in,
    input  wire logic                penable_in,
    input  wire logic                pwrite_in,
    input  wire logic [7:0]          paddr_in,
    input  wire logic [31:0]         pwdata_in,
    output logic                     pready_out,
    output logic                     pslverr_out,
    output logic [31:0]              prdata_out,
    // step interface pins
    input  wire logic                step_in,
    input  wire logic                dir_in,
    input  wire logic                resolution_select_a_in,
    input  wire logic                resolution_select_b_in,
    input  wire logic                resolution_select_c_in,
    input  wire logic                bridge_disable_in,
    // protection events
    input  wire logic                thermal_shutdown_in,
    input  wire logic                overcurrent_protection_in,
    // current comparators, one per phase
    input  wire logic [1:0]          trip_in,
    // per-phase dac, polarity, decay and bridge state
    output mtc_phase_type [1:0]      phase_out
);

////////////////////////////////////////////////////////////////////////////////
// helpers

    function automatic mtc_res_type res_decode(input logic a, input logic b, input logic c);
        case ({c, b, a})
            3'b000:  res_decode = RES_FULL;
            3'b001:  res_decode = RES_HALF;
            3'b010:  res_decode = RES_QUARTER;
            3'b011:  res_decode = RES_EIGHTH;
            3'b111:  res_decode = RES_SIXTEEN;
            default: res_decode = RES_SIXTEEN; // undefined pattern treated as finest
        endcase
    endfunction

    // quarter sine, 17 points, 255 = full-scale trip current
    function automatic logic [7:0] sine_tab(input logic [4:0] k);
        case (k)
            5'h00: sine_tab = 8'h00;
            5'h01: sine_tab = 8'h19;
            5'h02: sine_tab = 8'h32;
            5'h03: sine_tab = 8'h4A;
            5'h04: sine_tab = 8'h62;
            5'h05: sine_tab = 8'h79;
            5'h06: sine_tab = 8'h8E;
            5'h07: sine_tab = 8'hA2;
            5'h08: sine_tab = 8'hB4;
            5'h09: sine_tab = 8'hC5;
            5'h0A: sine_tab = 8'hD4;
            5'h0B: sine_tab = 8'hE1;
            5'h0C: sine_tab = 8'hEC;
            5'h0D: sine_tab = 8'hF4;
            5'h0E: sine_tab = 8'hFA;
            5'h0F: sine_tab = 8'hFE;
            default: sine_tab = 8'hFF;
        endcase
    endfunction

    function automatic logic [7:0] sine_mag(input logic [5:0] idx);
        logic [4:0] k;
        k = idx[4] ? 5'(5'h10 - {1'b0, idx[3:0]}) : {1'b0, idx[3:0]};
        sine_mag = sine_tab(k);
    endfunction

    // decay chosen from the level change that a step makes on one phase
    function automatic logic decay_pick(input mtc_offmode_type m, input mtc_res_type r,
                                        input logic [7:0] lvl_new, input logic [7:0] lvl_old);
        if (m == OFF_GROUNDED)
            decay_pick = 1'b1;
        else if (r == RES_FULL)
            decay_pick = 1'b0;
        else
            decay_pick = (lvl_new < lvl_old);
    endfunction

////////////////////////////////////////////////////////////////////////////////
// control register

    logic [1:0] mode_r;
    logic [7:0] offtime_config_pin_r;
    logic [31:0] prdata_r;

    wire logic setup_w     = psel_in & ~penable_in;
    wire logic access_w    = psel_in & penable_in;
    wire logic hit_ctrl_w  = (paddr_in == ADDR_CTRL);
    wire logic hit_stat_w  = (paddr_in == ADDR_STATUS);
    wire logic hit_phase_w = (paddr_in == ADDR_PHASE);
    wire logic mapped_w    = hit_ctrl_w | hit_stat_w | hit_phase_w;

    wire mtc_offmode_type mode_w = mtc_offmode_type'(mode_r);

    // off-time in cycles: fixed 30 us, or resistor (kohm) scaled by 1/825 us per ohm
    wire logic [CNT_W-1:0] offtime_config_pin_cyc_w = CNT_W'((32'(offtime_config_pin_r) * 32'(OFFTIME_CONFIG_PIN_MUL)) >> OFFTIME_CONFIG_PIN_SHIFT);
    wire logic [CNT_W-1:0] off_raw_w  = (mode_w == OFF_RESISTOR) ? offtime_config_pin_cyc_w : CNT_W'(OFF_CYC);
    // clamp keeps a tiny resistor setting from shrinking the off-time to a few cycles
    wire logic [CNT_W-1:0] off_cyc_w  = (off_raw_w < CNT_W'(OFF_MIN_CYC)) ? CNT_W'(OFF_MIN_CYC) : off_raw_w;
    // 5/16 is exactly 31.25 percent, so only the final shift truncates
    wire logic [CNT_W-1:0] fast_cyc_w = CNT_W'((32'(off_cyc_w) * 32'(FAST_NUM)) >> FAST_SHIFT);
    wire logic [CNT_W-1:0] slow_cyc_w = CNT_W'(off_cyc_w - fast_cyc_w);

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            mode_r <= CTRL_MODE_RST;
            offtime_config_pin_r <= CTRL_OFFTIME_CONFIG_PIN_RST;
        end else if (access_w && pwrite_in && hit_ctrl_w) begin
            mode_r <= pwdata_in[CTRL_MODE_LSB +: 2];
            offtime_config_pin_r <= pwdata_in[CTRL_OFFTIME_CONFIG_PIN_LSB +: 8];
        end
    end

////////////////////////////////////////////////////////////////////////////////
// translator

    logic        step_d_r;
    logic [5:0]  idx_r;
    mtc_res_type res_r;
    logic        dir_r;
    logic [1:0]  mixed_r;

    // faults act as levels: the index stays at Home for as long as either is high
    wire logic hold_home_w = thermal_shutdown_in | overcurrent_protection_in;
    wire logic step_rise_w = step_in & ~step_d_r;
    wire mtc_res_type res_w = res_decode(resolution_select_a_in, resolution_select_b_in,
                                         resolution_select_c_in);
    wire logic [5:0] inc_w = 6'h10 >> res_w;
    // direction and resolution are sampled only here, at the step edge
    wire logic [5:0] idx_nxt = dir_in ? 6'(idx_r + inc_w) : 6'(idx_r - inc_w);

    // phase 1 follows cosine, phase 2 sine; sign from upper half of the cycle
    wire logic [7:0] mag_old_w [2];
    wire logic [7:0] mag_new_w [2];
    wire logic [1:0] pol_w;
    wire logic [1:0] mixed_nxt_w;

    genvar q;
    generate
        for (q = 0; q < 2; q++) begin : g_level
            // the cosine phase leads by a quarter of the 64-entry cycle
            wire logic [5:0] pos_old_w = (q == 0) ? 6'(idx_r + QUARTER) : idx_r;
            wire logic [5:0] pos_new_w = (q == 0) ? 6'(idx_nxt + QUARTER) : idx_nxt;
            assign mag_old_w[q]   = sine_mag(pos_old_w);
            assign mag_new_w[q]   = sine_mag(pos_new_w);
            assign pol_w[q]       = ~idx_nxt_q(pos_old_w);
            assign mixed_nxt_w[q] = decay_pick(mode_w, res_w, mag_new_w[q], mag_old_w[q]);
        end
    endgenerate

    // sign of a phase: the upper half of the 64-entry cycle is negative
    function automatic logic idx_nxt_q(input logic [5:0] idx);
        idx_nxt_q = idx[5];
    endfunction

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            step_d_r <= 1'b1;      // a step held high through reset is not counted
            idx_r    <= HOME_IDX;
            res_r    <= RES_FULL;
            dir_r    <= 1'b1;
            mixed_r  <= 2'b11;
        end else begin
            step_d_r <= step_in;
            if (hold_home_w) begin
                idx_r   <= HOME_IDX;
                mixed_r <= 2'b11;
            end else if (step_rise_w) begin
                idx_r <= idx_nxt;
                res_r <= res_w;
                dir_r <= dir_in;
                mixed_r <= mixed_nxt_w;
            end
        end
    end

////////////////////////////////////////////////////////////////////////////////
// choppers, one per full-bridge

    // disable stops the choppers only; translator above runs regardless
    wire logic kill_w = bridge_disable_in | hold_home_w;

    mtc_chop_type   chop_r [2];
    logic [CNT_W-1:0] cnt_r [2];
    mtc_phase_type  phase_r [2];

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_phase
            mtc_chop_type     st_nxt;
            logic [CNT_W-1:0] cnt_nxt;
            mtc_bridge_type   br_nxt;

            always_comb begin
                st_nxt  = chop_r[g];
                cnt_nxt = (cnt_r[g] != '0) ? CNT_W'(cnt_r[g] - 1'b1) : cnt_r[g];
                case (chop_r[g])
                    CH_IDLE: begin
                        st_nxt  = CH_BLANK;
                        // every duration is a count of system clock cycles
                        cnt_nxt = CNT_W'(BLANK_CYC - 1);
                    end
                    CH_BLANK: begin
                        if (cnt_r[g] == '0)
                            st_nxt = CH_ON;
                    end
                    CH_ON: begin
                        if (trip_in[g]) begin
                            st_nxt  = mixed_r[g] ? CH_FAST : CH_SLOW;
                            cnt_nxt = mixed_r[g] ? CNT_W'(fast_cyc_w - 1'b1) : CNT_W'(off_cyc_w - 1'b1);
                        end
                    end
                    CH_FAST: begin
                        if (cnt_r[g] == '0) begin
                            st_nxt  = CH_SLOW;
                            cnt_nxt = CNT_W'(slow_cyc_w - 1'b1);
                        end
                    end
                    CH_SLOW: begin
                        if (cnt_r[g] == '0) begin
                            st_nxt  = CH_BLANK;
                            cnt_nxt = CNT_W'(BLANK_CYC - 1);
                        end
                    end
                    // an unused state code falls back to idle with the bridge off
                    default: begin
                        st_nxt  = CH_IDLE;
                        cnt_nxt = '0;
                    end
                endcase
                if (kill_w) begin
                    st_nxt  = CH_IDLE;
                    cnt_nxt = '0;
                end
                case (st_nxt)
                    CH_BLANK, CH_ON: br_nxt = BR_DRIVE;
                    CH_FAST:         br_nxt = BR_FAST;
                    CH_SLOW:         br_nxt = BR_SLOW;
                    default:         br_nxt = BR_OFF;
                endcase
            end

            always_ff @(posedge clk_in) begin
                if (!rstn_in) begin
                    chop_r[g]  <= CH_IDLE;
                    cnt_r[g]   <= '0;
                    phase_r[g] <= '{polarity: 1'b1, dac: sine_tab(5'h08), mixed: 1'b1, bridge: BR_OFF};
                end else begin
                    chop_r[g]         <= st_nxt;
                    cnt_r[g]          <= cnt_nxt;
                    phase_r[g].bridge <= br_nxt;
                    phase_r[g].mixed  <= mixed_r[g];
                    phase_r[g].dac    <= (g == 0) ? mag_old_w[0] : mag_old_w[1];
                    phase_r[g].polarity <= pol_w[g];
                end
            end
        end
    endgenerate

    assign phase_out = {phase_r[1], phase_r[0]};

////////////////////////////////////////////////////////////////////////////////
// apb read path: data latched in setup, presented in access

    wire logic [31:0] stat_rd_w = {16'h0000, dir_r, mixed_r, res_r, phase_r[1].bridge,
                                   phase_r[0].bridge, idx_r};
    wire logic [31:0] phase_rd_w = {13'h0000, phase_r[1].polarity, phase_r[1].dac,
                                    1'b0, phase_r[0].polarity, phase_r[0].dac};
    wire logic [31:0] ctrl_rd_w  = {16'h0000, offtime_config_pin_r, 6'h00, mode_r};
    wire logic [31:0] rd_mux_w   = hit_ctrl_w  ? ctrl_rd_w  :
                                   hit_stat_w  ? stat_rd_w  :
                                   hit_phase_w ? phase_rd_w : 32'h0000_0000;

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            prdata_r <= 32'h0000_0000;
        end else if (setup_w && !pwrite_in) begin
            prdata_r <= rd_mux_w;
        end
    end

    // no wait states: every register answers in its access cycle
    assign pready_out  = 1'b1;
    assign pslverr_out = access_w & ~mapped_w;
    assign prdata_out  = prdata_r;

endmodule

// ===== dv/mtc_translator_chopper_properties.sv
// port checker for the translator/chopper block
// assumes default package timing; bound to the design below
`timescale 1ns/100ps
module mtc_translator_chopper_properties
    import mtc_pkg::*;
(
    // clock and reset
    input wire logic                clk_in,
    input wire logic                rstn_in,
    // apb
    input wire logic                psel_in,
    input wire logic                penable_in,
    input wire logic [7:0]          paddr_in,
    input wire logic                pready_out,
    input wire logic                pslverr_out,
    // pins
    input wire logic                bridge_disable_in,
    input wire logic                thermal_shutdown_in,
    input wire logic                overcurrent_protection_in,
    input wire mtc_phase_type [1:0] phase_out
);
    localparam int            FAST_CYC = (OFF_CYC * FAST_NUM) >> FAST_SHIFT;
    localparam mtc_phase_type RST_PH   = '{polarity: 1'b1, dac: 8'hB4, mixed: 1'b1, bridge: BR_OFF};
    mtc_bridge_type br;
    mtc_bridge_type prev_r;
    int             run_r;
    int             off_r;
    logic           mapped;
    logic           both_off;
    assign br       = phase_out[0].bridge;
    assign mapped   = paddr_in == ADDR_CTRL || paddr_in == ADDR_STATUS || paddr_in == ADDR_PHASE;
    assign both_off = phase_out[0].bridge == BR_OFF && phase_out[1].bridge == BR_OFF;
    ////////////////////////////////////////////////////////////////
    // run lengths of the phase 0 bridge state, counted up to the previous cycle
    always_ff @(posedge clk_in) begin
        prev_r <= br;
        run_r  <= (br == prev_r) ? run_r + 1 : 1;
        off_r  <= (br == BR_FAST || br == BR_SLOW) ? off_r + 1 : 0;
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    a_reset_home: assert property (disable iff (1'b0) !rstn_in |=> phase_out[0] == RST_PH && phase_out[1] == RST_PH)
        else $error("reset state wrong");
    a_disable_kills: assert property (bridge_disable_in |=> both_off)
        else $error("bridges on while disabled");
    a_fault_kills: assert property (thermal_shutdown_in || overcurrent_protection_in |=> both_off)
        else $error("bridges on during fault");
    a_apb_ready: assert property (psel_in && penable_in |-> pready_out)
        else $error("no ready in access");
    a_unmapped_err: assert property (psel_in && penable_in |-> pslverr_out == !mapped)
        else $error("slave error wrong");
    a_blank_hold: assert property (prev_r == BR_DRIVE && (br == BR_FAST || br == BR_SLOW) |-> run_r >= BLANK_CYC)
        else $error("trip acted inside blanking");
    a_fast_share: assert property (prev_r == BR_FAST && br == BR_SLOW |-> run_r == FAST_CYC)
        else $error("fast decay length wrong");
    a_off_time: assert property (prev_r == BR_SLOW && br == BR_DRIVE |-> off_r == OFF_CYC)
        else $error("off-time length wrong");
    c_fast_slow: cover property (prev_r == BR_FAST && br == BR_SLOW);
    c_unmapped: cover property (psel_in && penable_in && !mapped);
    c_disabled: cover property (bridge_disable_in ##1 both_off);
endmodule
bind mtc_translator_chopper mtc_translator_chopper_properties u_props (
    .clk_in(clk_in), .rstn_in(rstn_in), .psel_in(psel_in), .penable_in(penable_in),
    .paddr_in(paddr_in), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .bridge_disable_in(bridge_disable_in), .thermal_shutdown_in(thermal_shutdown_in),
    .overcurrent_protection_in(overcurrent_protection_in), .phase_out(phase_out));

// ===== dv/mtc_step_host.sv
// step-pulse host: one whole step pulse per go request
// assumes go is raised for one cycle while busy is low
`timescale 1ns/100ps
module mtc_step_host
#(
    parameter int HIGH_CYC = 100,
    parameter int LOW_CYC  = 100
) (
    // clock and request
    input  wire logic clk_in,
    input  wire logic go_in,
    // pin toward the block
    output logic      step_out,
    output logic      busy_out
);
    logic step_r = 1'b0;
    logic busy_r = 1'b0;
    int   cnt_r  = 0;
    ////////////////////////////////////////////////////////////////
    // no sleep pin on this block, so the wake-up wait before a first pulse never arises
    // busy covers the low time too, so the next pulse cannot come early
    always @(posedge clk_in) begin
        if (!busy_r && go_in) begin
            busy_r <= 1'b1;
            step_r <= 1'b1;
            cnt_r <= 0;
        end else if (busy_r) begin
            cnt_r <= cnt_r + 1;
            if (cnt_r == HIGH_CYC - 1)
                step_r <= 1'b0;
            if (cnt_r == HIGH_CYC + LOW_CYC - 1)
                busy_r <= 1'b0;
        end
    end
    assign step_out = step_r;
    assign busy_out = busy_r;
endmodule

// ===== dv/mtc_translator_chopper_test.sv
// self-checking bench for the translator/chopper block
// assumes mtc_step_host as step source and the bound port checker
`timescale 1ns/100ps
module mtc_translator_chopper_test
    import mtc_pkg::*;
    ;
    localparam logic [2:0] PINS [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
    logic                clk_in = 1'b0;
    logic                rstn_in = 1'b0;
    logic                psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic                go = 1'b0, dir = 1'b1, dis = 1'b0, thermal_shutdown = 1'b0, overcurrent_protection = 1'b0;
    logic [2:0]          cba = 3'h0;
    logic [1:0]          trip = 2'h0;
    logic [7:0]          paddr = 8'h00;
    logic [31:0]         pwdata = 32'h0;
    logic [31:0]         prdata, rd;
    logic                pready, pslverr, step, busy, err;
    mtc_phase_type [1:0] phase;
    int                  fails = 0, checks_done = 0, cyc = 0, idx = 8;
    ////////////////////////////////////////////////////////////////
    mtc_translator_chopper u_dut (.clk_in(clk_in), .rstn_in(rstn_in), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready), .pslverr_out(pslverr),
        .prdata_out(prdata), .step_in(step), .dir_in(dir), .resolution_select_a_in(cba[0]),
        .resolution_select_b_in(cba[1]), .resolution_select_c_in(cba[2]), .bridge_disable_in(dis),
        .thermal_shutdown_in(thermal_shutdown), .overcurrent_protection_in(overcurrent_protection), .trip_in(trip), .phase_out(phase));
    mtc_step_host u_host (.clk_in(clk_in), .go_in(go), .step_out(step), .busy_out(busy));
    always #5 clk_in = ~clk_in;
    task automatic tally_and_finish();
        if (fails == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        pen <= 1'b1;
        do @(posedge clk_in); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic fld(input logic [7:0] a, input int lsb, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk((rd >> lsb) & m, e);
    endtask
    task automatic step_once();
        go <= 1'b1;
        @(posedge clk_in);
        go <= 1'b0;
        do @(posedge clk_in); while (busy !== 1'b0);
    endtask
    // a hang counts as a mismatch
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 60000) begin
            fails++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (8) @(posedge clk_in);
        rstn_in <= 1'b1;
        @(posedge clk_in);
        fld(ADDR_STATUS, 0, 32'h603F, 32'h6008);
        fld(ADDR_PHASE, 0, 32'hFFFFFFFF, 32'h0006D1B4);
        trip <= 2'h3;
        while (phase[0].bridge !== BR_FAST) @(posedge clk_in);
        fld(ADDR_STATUS, 6, 32'hF, 32'hA);
        while (phase[0].bridge !== BR_DRIVE) @(posedge clk_in);
        repeat (50) @(posedge clk_in);
        chk(phase[1].bridge, BR_DRIVE);
        trip <= 2'h0;
        for (int i = 0; i < 5; i++) begin
            cba <= PINS[i];
            step_once();
            idx = (idx + (16 >> i)) % 64;
            fld(ADDR_STATUS, 0, 32'h1C3F, (i << 10) | idx);
            if (i == 0)
                fld(ADDR_STATUS, 13, 32'h3, 32'h0);
        end
        cba <= 3'h0;
        dir <= 1'b0;
        repeat (10) @(posedge clk_in);
        fld(ADDR_STATUS, 0, 32'h9C3F, 32'h9027);
        step_once();
        fld(ADDR_STATUS, 0, 32'h9C3F, 32'h0017);
        apb(1'b1, ADDR_CTRL, 32'h1901);
        fld(ADDR_CTRL, 0, 32'hFF03, 32'h1901);
        step_once();
        fld(ADDR_STATUS, 0, 32'h603F, 32'h6007);
        apb(1'b1, ADDR_CTRL, 32'h1902);
        step_once();
        fld(ADDR_STATUS, 0, 32'h603F, 32'h0037);
        fld(ADDR_PHASE, 0, 32'h00040100, 32'h00000100);
        dis <= 1'b1;
        step_once();
        fld(ADDR_STATUS, 0, 32'h3FF, 32'h027);
        dis <= 1'b0;
        thermal_shutdown <= 1'b1;
        repeat (3) @(posedge clk_in);
        thermal_shutdown <= 1'b0;
        fld(ADDR_STATUS, 0, 32'h3F, 32'h8);
        step_once();
        overcurrent_protection <= 1'b1;
        repeat (3) @(posedge clk_in);
        overcurrent_protection <= 1'b0;
        fld(ADDR_STATUS, 0, 32'h3F, 32'h8);
        step_once();
        rstn_in <= 1'b0;
        step_once();
        rstn_in <= 1'b1;
        @(posedge clk_in);
        fld(ADDR_STATUS, 0, 32'h3F, 32'h8);
        apb(1'b0, 8'h0C, 32'h0);
        chk(err, 1'b1);
        chk(rd, 32'h0);
        apb(1'b1, ADDR_STATUS, 32'hFFFFFFFF);
        fld(ADDR_STATUS, 0, 32'h3F, 32'h8);
        tally_and_finish();
    end
endmodule
